// ===== rtl/tmc_pkg.sv
// shared constants and types for the timer/counter block
package tmc_pkg;
  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int MCYC_CLKS = 12;
  localparam logic [3:0] MCYC_LAST = 4'(MCYC_CLKS - 1);
  localparam logic [3:0] MCYC_ONE = 4'h1;

  // ----------------------------------------------------------------
  // widths and counting constants
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_MAX = 5'h1F;
  localparam logic [PRE_W-1:0] PRE_ONE = 5'h01;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] HALF_MAX = 16'hFFFF;
  localparam logic [15:0] HALF_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] ADDR_TMODE = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_TCTRL = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_T0CNT = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_T1CNT = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_TIMER2_CONTROL = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_TIMER2_MODE_REGISTER = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_T2CNT = 8'h18;
  localparam logic [APB_AW-1:0] ADDR_RCAP = 8'h1C;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [31:0] tmc_word_t;

  typedef enum logic [1:0] {
    TM_13BIT = 2'h0,
    TM_16BIT = 2'h1,
    TM_RELOAD8 = 2'h2,
    TM_SPLIT = 2'h3
  } tmc_tmode_e;

  // one nibble of the standard timer mode register
  typedef struct packed {
    logic gate;
    logic cs;
    tmc_tmode_e mode;
  } tmc_tcfg_s;

  typedef struct packed {
    logic t1_overflow_flag;
    logic t1_run_bit;
    logic t0_overflow_flag;
    logic t0_run_bit;
  } tmc_tctrl_s;

  // timer2_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic t2_overflow_flag;
    logic t2_external_flag;
    logic rx_clock_select_port1;
    logic tx_clock_select_port1;
    logic t2_external_enable;
    logic t2_run_bit;
    logic t2_counter_select;
    logic capture_reload_select;
  } tmc_timer2_control_s;

  typedef struct packed {
    logic tx_clock_select_port2;
    logic rx_clock_select_port2;
    logic down_count_enable;
  } tmc_timer2_mode_register_s;

  typedef struct packed {
    logic t0_count_pin;
    logic t1_count_pin;
    logic t2_count_pin;
    logic t2_trigger_input;
    logic ext_irq_pin_a;
    logic ext_irq_pin_b;
  } tmc_pins_s;

  localparam int PIN_N = $bits(tmc_pins_s);

  typedef struct packed {
    logic [PIN_N-1:0] meta;
    logic [PIN_N-1:0] sync;
    logic [PIN_N-1:0] prev;
  } tmc_sync_s;

  typedef struct packed {
    logic rx1;
    logic tx1;
    logic rx2;
    logic tx2;
  } tmc_baud_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } tmc_apb_req_s;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } tmc_tstep_s;
endpackage

// ===== rtl/tmc_sync.sv
// two-flop synchronisers with falling-edge detectors for the pin inputs
module tmc_sync
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire tmc_pkg::tmc_pins_s pins_in,
  output tmc_pkg::tmc_pins_s level,
  output tmc_pkg::tmc_pins_s fall
);
  import tmc_pkg::*;

  tmc_sync_s st_r;
  tmc_sync_s st_nxt;
  logic [PIN_N-1:0] fall_v;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = pins_in;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // idle-high reset so the release never looks like a falling edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  genvar i;
  for (i = 0; i < PIN_N; i++)
  begin : g_pin
    assign fall_v[i] = st_r.prev[i] & ~st_r.sync[i];
  end

  assign level = tmc_pins_s'(st_r.sync);
  assign fall = tmc_pins_s'(fall_v);
endmodule

// ===== rtl/tmc_top.sv
// three timer/counters with auto-reload, split mode, capture and baud generation
// ----------------------------------------------------------------
// Overview of operation
// - mode 2: low byte reloads from high
// - timer 1 in mode 3 holds count
// - t0 mode 3: low byte own counter
// - t0 mode 3: high byte uses t1 controls
// - t1 still runs as baud source
// - counter select: machine cycle or pin
// - capture mode: 16-bit counter, overflow flag
// - trigger fall captures count, sets flag
// - auto-reload mode reloads on rollover
// - trigger fall also reloads, sets flag
// - baud mode never sets overflow flag
// - baud mode forces auto-reload
// - clock selects route t2 or t1 overflow
// - trigger ignored unless enabled, not down mode
// - baud mode trigger sets external flag
// - timer 2 counts only when running
// - flags hardware set, software cleared
// - capture mode counts up only
// - gate and run enable counted input
// ----------------------------------------------------------------
module tmc_top
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire tmc_pkg::tmc_apb_req_s apb_req,
  output tmc_pkg::tmc_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire tmc_pkg::tmc_pins_s pins,
  output tmc_pkg::tmc_baud_s baud_clk,
  output logic t0_irq,
  output logic t1_irq,
  output logic t2_irq
);
  import tmc_pkg::*;

  typedef struct packed {
    logic [3:0] mcyc_cnt;
    tmc_tcfg_s t1cfg;
    tmc_tcfg_s t0cfg;
    tmc_tctrl_s tctrl;
    logic [7:0] t0_lo;
    logic [7:0] t0_hi;
    logic [7:0] t1_lo;
    logic [7:0] t1_hi;
    tmc_timer2_control_s timer2_control;
    tmc_timer2_mode_register_s timer2_mode_register;
    logic [15:0] t2_cnt;
    logic [15:0] rcap;
    tmc_word_t rdata;
    logic rerr;
    tmc_baud_s baud;
  } tmc_state_s;

  tmc_state_s st_r;
  tmc_state_s st_nxt;
  tmc_pins_s lvl;
  tmc_pins_s fall;
  logic mcyc;
  logic t0_m3;
  logic t0_tick;
  logic t1_tick;
  logic th0_tick;
  logic th0_ovf;
  logic t1_ovf_ev;
  tmc_tstep_s t0_step;
  tmc_tstep_s t1_step;
  logic baud_mode;
  logic reload_mode;
  logic down_mode;
  logic count_down;
  logic t2_tick;
  logic t2_edge;
  logic up_wrap;
  logic dn_wrap;
  logic t2_wrap;
  logic setup_ph;
  logic access_ph;
  logic sw_wr;
  tmc_timer2_control_s w_timer2_control;

  tmc_sync u_sync
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins_in(pins),
    .level(lvl),
    .fall(fall)
  );

  // ----------------------------------------------------------------
  // one count step of a standard timer in the given mode
  // ----------------------------------------------------------------
  function automatic tmc_tstep_s tmc_step(input tmc_tmode_e mode, input logic [7:0] lo, input logic [7:0] hi);
    tmc_tstep_s r;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    case (mode)
      TM_13BIT:
      begin
        r.lo[PRE_W-1:0] = lo[PRE_W-1:0] + PRE_ONE;
        if (lo[PRE_W-1:0] == PRE_MAX)
        begin
          r.hi = hi + BYTE_ONE;
          r.ovf = (hi == BYTE_MAX);
        end
      end
      TM_16BIT:
      begin
        {r.hi, r.lo} = {hi, lo} + HALF_ONE;
        r.ovf = ({hi, lo} == HALF_MAX);
      end
      TM_RELOAD8:
      begin
        r.ovf = (lo == BYTE_MAX);
        r.lo = r.ovf ? hi : lo + BYTE_ONE;
      end
      default:
      begin
        r.lo = lo + BYTE_ONE;
        r.ovf = (lo == BYTE_MAX);
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    mcyc = (st_r.mcyc_cnt == MCYC_LAST);
    st_nxt.mcyc_cnt = mcyc ? '0 : st_r.mcyc_cnt + MCYC_ONE;

    // standard timers
    t0_m3 = (st_r.t0cfg.mode == TM_SPLIT);
    t0_tick = st_r.tctrl.t0_run_bit & (~st_r.t0cfg.gate | lvl.ext_irq_pin_a)
              & (st_r.t0cfg.cs ? fall.t0_count_pin : mcyc);
    // timer 1 ignores its run bit while timer 0 borrows it
    t1_tick = (st_r.t1cfg.mode != TM_SPLIT) & (t0_m3 | st_r.tctrl.t1_run_bit)
              & (~st_r.t1cfg.gate | lvl.ext_irq_pin_b)
              & (st_r.t1cfg.cs ? fall.t1_count_pin : mcyc);
    th0_tick = t0_m3 & st_r.tctrl.t1_run_bit & mcyc;
    th0_ovf = th0_tick & (st_r.t0_hi == BYTE_MAX);
    t0_step = tmc_step(st_r.t0cfg.mode, st_r.t0_lo, st_r.t0_hi);
    t1_step = tmc_step(st_r.t1cfg.mode, st_r.t1_lo, st_r.t1_hi);
    t1_ovf_ev = t1_tick & t1_step.ovf;
    if (t0_tick)
    begin
      st_nxt.t0_lo = t0_step.lo;
      st_nxt.t0_hi = t0_step.hi;
    end
    if (th0_tick)
    begin
      st_nxt.t0_hi = st_r.t0_hi + BYTE_ONE;
    end
    if (t1_tick)
    begin
      st_nxt.t1_lo = t1_step.lo;
      st_nxt.t1_hi = t1_step.hi;
    end

    // timer 2
    baud_mode = st_r.timer2_control.rx_clock_select_port1 | st_r.timer2_control.tx_clock_select_port1
                | st_r.timer2_mode_register.rx_clock_select_port2 | st_r.timer2_mode_register.tx_clock_select_port2;
    reload_mode = baud_mode | ~st_r.timer2_control.capture_reload_select;
    down_mode = reload_mode & ~baud_mode & st_r.timer2_mode_register.down_count_enable;
    count_down = down_mode & ~lvl.t2_trigger_input;
    t2_tick = st_r.timer2_control.t2_run_bit
              & (st_r.timer2_control.t2_counter_select ? fall.t2_count_pin : mcyc);
    t2_edge = fall.t2_trigger_input & st_r.timer2_control.t2_external_enable & ~down_mode;
    up_wrap = t2_tick & ~count_down & (st_r.t2_cnt == HALF_MAX);
    dn_wrap = t2_tick & count_down & (st_r.t2_cnt == st_r.rcap);
    t2_wrap = up_wrap | dn_wrap;
    if (t2_tick)
    begin
      st_nxt.t2_cnt = count_down ? st_r.t2_cnt - HALF_ONE : st_r.t2_cnt + HALF_ONE;
    end
    if (up_wrap & reload_mode)
    begin
      st_nxt.t2_cnt = st_r.rcap;
    end
    if (dn_wrap)
    begin
      st_nxt.t2_cnt = HALF_MAX;
    end
    if (t2_edge & ~baud_mode)
    begin
      if (reload_mode)
      begin
        st_nxt.t2_cnt = st_r.rcap;
      end
      else
      begin
        st_nxt.rcap = st_r.t2_cnt;
      end
    end

    // register writes, taken in the access phase
    setup_ph = apb_req.psel & ~apb_req.penable;
    access_ph = apb_req.psel & apb_req.penable;
    sw_wr = access_ph & apb_req.pwrite;
    w_timer2_control = tmc_timer2_control_s'(apb_req.pwdata[BYTE_W-1:0]);
    if (sw_wr)
    begin
      case (apb_req.paddr)
        ADDR_TMODE:
        begin
          {st_nxt.t1cfg, st_nxt.t0cfg} = apb_req.pwdata[BYTE_W-1:0];
        end
        ADDR_TCTRL:
        begin
          st_nxt.tctrl = tmc_tctrl_s'(apb_req.pwdata[$bits(tmc_tctrl_s)-1:0]);
          // flags only clear from software
          st_nxt.tctrl.t0_overflow_flag = st_r.tctrl.t0_overflow_flag & st_nxt.tctrl.t0_overflow_flag;
          st_nxt.tctrl.t1_overflow_flag = st_r.tctrl.t1_overflow_flag & st_nxt.tctrl.t1_overflow_flag;
        end
        ADDR_T0CNT:
        begin
          {st_nxt.t0_hi, st_nxt.t0_lo} = apb_req.pwdata[HALF_W-1:0];
        end
        ADDR_T1CNT:
        begin
          {st_nxt.t1_hi, st_nxt.t1_lo} = apb_req.pwdata[HALF_W-1:0];
        end
        ADDR_TIMER2_CONTROL:
        begin
          st_nxt.timer2_control = w_timer2_control;
          st_nxt.timer2_control.t2_overflow_flag = st_r.timer2_control.t2_overflow_flag & w_timer2_control.t2_overflow_flag;
          st_nxt.timer2_control.t2_external_flag = st_r.timer2_control.t2_external_flag & w_timer2_control.t2_external_flag;
        end
        ADDR_TIMER2_MODE_REGISTER:
        begin
          st_nxt.timer2_mode_register = tmc_timer2_mode_register_s'(apb_req.pwdata[$bits(tmc_timer2_mode_register_s)-1:0]);
        end
        ADDR_T2CNT:
        begin
          st_nxt.t2_cnt = apb_req.pwdata[HALF_W-1:0];
        end
        ADDR_RCAP:
        begin
          st_nxt.rcap = apb_req.pwdata[HALF_W-1:0];
        end
        default:
        begin
          st_nxt.rcap = st_nxt.rcap;
        end
      endcase
    end

    // hardware flag sets win over a software clear in the same cycle
    st_nxt.tctrl.t0_overflow_flag = st_nxt.tctrl.t0_overflow_flag | (t0_tick & t0_step.ovf);
    st_nxt.tctrl.t1_overflow_flag = st_nxt.tctrl.t1_overflow_flag
                                    | (t0_m3 ? th0_ovf : t1_ovf_ev);
    st_nxt.timer2_control.t2_overflow_flag = st_nxt.timer2_control.t2_overflow_flag | (t2_wrap & ~baud_mode);
    st_nxt.timer2_control.t2_external_flag = st_nxt.timer2_control.t2_external_flag | t2_edge;

    // read data captured in the setup phase
    if (setup_ph)
    begin
      st_nxt.rerr = 1'b0;
      case (apb_req.paddr)
        ADDR_TMODE: st_nxt.rdata = tmc_word_t'({st_r.t1cfg, st_r.t0cfg});
        ADDR_TCTRL: st_nxt.rdata = tmc_word_t'({st_r.tctrl});
        ADDR_T0CNT: st_nxt.rdata = tmc_word_t'({st_r.t0_hi, st_r.t0_lo});
        ADDR_T1CNT: st_nxt.rdata = tmc_word_t'({st_r.t1_hi, st_r.t1_lo});
        ADDR_TIMER2_CONTROL: st_nxt.rdata = tmc_word_t'({st_r.timer2_control});
        ADDR_TIMER2_MODE_REGISTER: st_nxt.rdata = tmc_word_t'({st_r.timer2_mode_register});
        ADDR_T2CNT: st_nxt.rdata = tmc_word_t'({st_r.t2_cnt});
        ADDR_RCAP: st_nxt.rdata = tmc_word_t'({st_r.rcap});
        default:
        begin
          st_nxt.rdata = '0;
          st_nxt.rerr = 1'b1;
        end
      endcase
    end

    // baud clock routing to the serial ports
    st_nxt.baud.rx1 = st_r.timer2_control.rx_clock_select_port1 ? t2_wrap : t1_ovf_ev;
    st_nxt.baud.tx1 = st_r.timer2_control.tx_clock_select_port1 ? t2_wrap : t1_ovf_ev;
    st_nxt.baud.rx2 = st_r.timer2_mode_register.rx_clock_select_port2 ? t2_wrap : t1_ovf_ev;
    st_nxt.baud.tx2 = st_r.timer2_mode_register.tx_clock_select_port2 ? t2_wrap : t1_ovf_ev;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = access_ph;
  assign pslverr = access_ph & st_r.rerr;
  assign baud_clk = st_r.baud;
  assign t0_irq = st_r.tctrl.t0_overflow_flag;
  assign t1_irq = st_r.tctrl.t1_overflow_flag;
  assign t2_irq = st_r.timer2_control.t2_overflow_flag | st_r.timer2_control.t2_external_flag;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  reload8_wrap_a: assert property ((st_r.t0cfg.mode == TM_RELOAD8) && t0_tick && (st_r.t0_lo == BYTE_MAX)
    && !sw_wr |=> (st_r.t0_lo == $past(st_r.t0_hi)) && $stable(st_r.t0_hi) && st_r.tctrl.t0_overflow_flag)
    else $error("mode 2 reload of timer 0 low byte wrong");

  t1_split_hold_a: assert property ((st_r.t1cfg.mode == TM_SPLIT) && !sw_wr
    |=> $stable({st_r.t1_hi, st_r.t1_lo}))
    else $error("timer 1 moved while in mode 3");

  t0lo_split_a: assert property (t0_m3 && t0_tick && (st_r.t0_lo == BYTE_MAX) && !sw_wr
    |=> (st_r.t0_lo == '0) && st_r.tctrl.t0_overflow_flag)
    else $error("split low byte overflow wrong");

  th0_flag_a: assert property (th0_tick && (st_r.t0_hi == BYTE_MAX) |=> st_r.tctrl.t1_overflow_flag)
    else $error("split high byte overflow did not set timer 1 flag");

  baud_no_flag_a: assert property (baud_mode && !st_r.timer2_control.t2_overflow_flag ##1 baud_mode
    |-> !st_r.timer2_control.t2_overflow_flag)
    else $error("timer 2 overflow flag set in baud mode");

  t2_reload_a: assert property (reload_mode && up_wrap && !t2_edge && !sw_wr
    |=> st_r.t2_cnt == $past(st_r.rcap))
    else $error("timer 2 did not reload on rollover");

  t2_capture_a: assert property (t2_edge && !reload_mode && !sw_wr
    |=> (st_r.rcap == $past(st_r.t2_cnt)) && st_r.timer2_control.t2_external_flag)
    else $error("timer 2 capture wrong");

  t2_stop_a: assert property (!st_r.timer2_control.t2_run_bit && !t2_edge && !sw_wr |=> $stable(st_r.t2_cnt))
    else $error("timer 2 counted while stopped");

  capture_up_a: assert property (!reload_mode && t2_tick && !sw_wr && (st_r.t2_cnt != HALF_MAX)
    |=> st_r.t2_cnt == $past(st_r.t2_cnt) + HALF_ONE)
    else $error("capture mode did not count up");

  flag_sticky_a: assert property (st_r.timer2_control.t2_external_flag && !sw_wr |=> st_r.timer2_control.t2_external_flag)
    else $error("external flag cleared without software");

  baud_route_a: assert property (st_r.timer2_control.rx_clock_select_port1 && t2_wrap
    |=> baud_clk.rx1 ##1 !baud_clk.rx1)
    else $error("timer 2 overflow not routed to receive clock");

  trig_ignored_a: assert property (!st_r.timer2_control.t2_external_enable && !st_r.timer2_control.t2_external_flag && !sw_wr
    |=> !st_r.timer2_control.t2_external_flag)
    else $error("trigger acted while external enable clear");

  cover_capture_c: cover property (t2_edge && !reload_mode);
  cover_reload8_c: cover property ((st_r.t0cfg.mode == TM_RELOAD8) && t0_tick && t0_step.ovf);
  cover_baud_c: cover property (baud_mode && t2_wrap ##1 baud_clk.tx1);
  cover_th0_c: cover property (th0_ovf);
endmodule

// ===== dv/tmc_far_model.sv
// far-side model: count, trigger and gate pins, and baud pulse counters
module tmc_far_model
(
  input wire logic clk,
  input wire tmc_pkg::tmc_baud_s baud_clk,
  output tmc_pkg::tmc_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  int n_b[4];

  initial
  begin
    pins = '1;
    n_b = '{0, 0, 0, 0};
  end

  // ------------------------------------------------
  // pin stimulus and pulse counting
  // ------------------------------------------------
  // counts one-cycle pulses on each serial clock line
  always @(posedge clk)
  begin
    for (int k = 0; k < 4; k++)
      n_b[k] <= n_b[k] + int'(baud_clk[k]);
  end

  task set_pin(input int b, input logic v);
    @(posedge clk);
    pins[b] <= v;
  endtask

  // falling edges held long enough to pass the synchronisers
  task pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge clk);
      pins[b] <= 1'b0;
      repeat (4) @(posedge clk);
      pins[b] <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the timer/counter block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  localparam int PT = 2;
  localparam int PC = 3;
  localparam int PG = 1;
  localparam int P0 = 5;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  tmc_apb_req_s req = '0;
  tmc_word_t prdata;
  logic pready;
  logic pslverr;
  tmc_pins_s pins;
  tmc_baud_s baud_clk;
  logic t0_irq;
  logic t1_irq;
  logic t2_irq;
  wire logic [2:0] irqs = {t2_irq, t1_irq, t0_irq};
  int n_fail = 0;
  int num_checks = 0;
  int base[4];
  logic [15:0] lfsr = 16'h000C;
  logic last_err = 1'b0;
  tmc_word_t d;
  tmc_word_t c;
  logic [15:0] r;

  always #5 clk = ~clk;

  tmc_top i_dut (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .baud_clk(baud_clk), .t0_irq(t0_irq), .t1_irq(t1_irq), .t2_irq(t2_irq));
  tmc_far_model i_far (.clk(clk), .baud_clk(baud_clk), .pins(pins));

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task chk(input tmc_word_t got, input tmc_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic is_wr, input logic [7:0] a, input tmc_word_t wd);
    int n;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= is_wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      results();
    end
    d = prdata;
    last_err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input tmc_word_t wd);
    apb(1'b1, a, wd);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, '0);
  endtask

  task rdchk(input logic [7:0] a, input tmc_word_t exp);
    rd(a);
    chk(d, exp);
  endtask

  task wait_irq(input int i);
    for (int n = 0; n < 40 && irqs[i] !== 1'b1; n++)
      @(posedge clk);
    chk(32'(irqs[i]), 1);
  endtask

  task snap();
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++)
      base[k] = i_far.n_b[k];
  endtask

  task baud_chk(input int lo, input int hi);
    for (int k = 0; k < 4; k++)
      chk(32'(i_far.n_b[k] - base[k] >= lo && i_far.n_b[k] - base[k] <= hi), 1);
  endtask

  task results();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    results();
  end

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(ADDR_TIMER2_CONTROL, 0);
    rdchk(8'h20, 0);
    chk(32'(last_err), 1);
    wr(ADDR_TCTRL, 32'h0A);
    rdchk(ADDR_TCTRL, 0);
    wr(ADDR_TIMER2_CONTROL, 32'hC0);
    rdchk(ADDR_TIMER2_CONTROL, 0);
    wr(ADDR_TMODE, 32'h02);
    for (int k = 0; k < 3; k++)
    begin
      r = rnd();
      wr(ADDR_T0CNT, {16'h0, r[7:0], 8'hFF});
      wr(ADDR_TCTRL, 32'h1);
      wait_irq(0);
      rdchk(ADDR_T0CNT, {16'h0, r[7:0], r[7:0]});
      rdchk(ADDR_TCTRL, 32'h3);
      wr(ADDR_TCTRL, 32'h0);
    end
    wr(ADDR_TMODE, 32'h03);
    wr(ADDR_T0CNT, 32'hFF10);
    wr(ADDR_TCTRL, 32'h4);
    wait_irq(1);
    chk(32'(t0_irq), 0);
    rdchk(ADDR_T0CNT, 32'h0010);
    wr(ADDR_TCTRL, 32'h0);
    wr(ADDR_T0CNT, 32'h50FF);
    wr(ADDR_TCTRL, 32'h1);
    wait_irq(0);
    rdchk(ADDR_T0CNT, 32'h5000);
    rdchk(ADDR_TCTRL, 32'h3);
    wr(ADDR_TCTRL, 32'h4);
    wr(ADDR_TMODE, 32'h23);
    wr(ADDR_T1CNT, 32'hFFFF);
    snap();
    repeat (120) @(posedge clk);
    baud_chk(9, 11);
    wr(ADDR_TMODE, 32'h33);
    snap();
    repeat (120) @(posedge clk);
    baud_chk(0, 0);
    wr(ADDR_TMODE, 32'h30);
    r = rnd();
    wr(ADDR_T1CNT, {16'h0, r});
    repeat (60) @(posedge clk);
    rdchk(ADDR_T1CNT, {16'h0, r});
    wr(ADDR_TCTRL, 32'h0);
    wr(ADDR_TMODE, 32'h09);
    i_far.set_pin(PG, 1'b0);
    wr(ADDR_T0CNT, 32'h1234);
    wr(ADDR_TCTRL, 32'h1);
    repeat (60) @(posedge clk);
    rdchk(ADDR_T0CNT, 32'h1234);
    i_far.set_pin(PG, 1'b1);
    repeat (60) @(posedge clk);
    rd(ADDR_T0CNT);
    chk(32'(d > 32'h1234), 1);
    wr(ADDR_TCTRL, 32'h0);
    wr(ADDR_TMODE, 32'h07);
    wr(ADDR_T0CNT, 32'h0);
    wr(ADDR_TCTRL, 32'h1);
    i_far.pulse(P0, 3);
    rdchk(ADDR_T0CNT, 32'h3);
    wr(ADDR_TCTRL, 32'h0);
    wr(ADDR_TIMER2_MODE_REGISTER, 32'h1);
    wr(ADDR_T2CNT, 32'hFFFF);
    wr(ADDR_TIMER2_CONTROL, 32'h05);
    wait_irq(2);
    rdchk(ADDR_TIMER2_CONTROL, 32'h85);
    rd(ADDR_T2CNT);
    chk(32'(d < 32'h10), 1);
    wr(ADDR_TIMER2_CONTROL, 32'h05);
    i_far.pulse(PT, 1);
    rdchk(ADDR_TIMER2_CONTROL, 32'h05);
    rdchk(ADDR_RCAP, 0);
    wr(ADDR_TIMER2_CONTROL, 32'h0D);
    i_far.pulse(PT, 1);
    rdchk(ADDR_TIMER2_CONTROL, 32'h4D);
    rd(ADDR_RCAP);
    c = d;
    rd(ADDR_T2CNT);
    chk(32'(d - c < 4), 1);
    r = rnd();
    r[15] = 1'b0;
    wr(ADDR_TIMER2_CONTROL, 32'h00);
    wr(ADDR_TIMER2_MODE_REGISTER, 32'h0);
    wr(ADDR_RCAP, {16'h0, r});
    wr(ADDR_T2CNT, 32'hFFFF);
    wr(ADDR_TIMER2_CONTROL, 32'h04);
    wait_irq(2);
    rdchk(ADDR_T2CNT, {16'h0, r});
    wr(ADDR_TIMER2_CONTROL, 32'h0C);
    wr(ADDR_T2CNT, 32'hC000);
    i_far.pulse(PT, 1);
    rd(ADDR_T2CNT);
    chk(32'(d - r < 3), 1);
    rdchk(ADDR_TIMER2_CONTROL, 32'h4C);
    wr(ADDR_TIMER2_MODE_REGISTER, 32'h1);
    wr(ADDR_TIMER2_CONTROL, 32'h04);
    i_far.set_pin(PT, 1'b0);
    wr(ADDR_T2CNT, 32'h8000);
    repeat (60) @(posedge clk);
    rd(ADDR_T2CNT);
    chk(32'(d < 32'h8000 && d > 32'h7F00), 1);
    i_far.set_pin(PT, 1'b1);
    wr(ADDR_TIMER2_CONTROL, 32'h00);
    wr(ADDR_T2CNT, 32'h2222);
    repeat (60) @(posedge clk);
    rdchk(ADDR_T2CNT, 32'h2222);
    wr(ADDR_TIMER2_MODE_REGISTER, 32'h0);
    wr(ADDR_T2CNT, 32'h0);
    wr(ADDR_TIMER2_CONTROL, 32'h06);
    i_far.pulse(PC, 5);
    rdchk(ADDR_T2CNT, 32'h5);
    wr(ADDR_TIMER2_CONTROL, 32'h00);
    wr(ADDR_RCAP, 32'hFFFE);
    wr(ADDR_T2CNT, 32'hFFFE);
    wr(ADDR_TIMER2_MODE_REGISTER, 32'h6);
    wr(ADDR_TIMER2_CONTROL, 32'h35);
    snap();
    repeat (120) @(posedge clk);
    baud_chk(4, 6);
    rdchk(ADDR_TIMER2_CONTROL, 32'h35);
    wr(ADDR_TIMER2_CONTROL, 32'h3D);
    i_far.pulse(PT, 1);
    rdchk(ADDR_TIMER2_CONTROL, 32'h7D);
    rdchk(ADDR_RCAP, 32'hFFFE);
    chk(32'(t2_irq), 1);
    results();
  end
endmodule
